// ---- core/dmc_defines.svh ----
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

// switch bank bit positions, switch n at bit n-1
`define DMC_SW_TEST_LO 0
`define DMC_SW_TEST_HI 2
`define DMC_SW_MODE 3
`define DMC_SW_MAP 4
`define DMC_SW_SIDES 5
`define DMC_SW_EXT 6
`define DMC_SW_COUNT 7

// switch level reads, closed is 0 and open is 1
`define DMC_SW_CLOSED 1'h0
`define DMC_SW_OPEN 1'h1

// register indices
`define DMC_REG_SWITCH 4'h0
`define DMC_REG_CONFIG 4'h1
`define DMC_REG_CTRL 4'h2

// control register field positions
`define DMC_CTRL_REINIT 0

// factory default switch pattern: mode 2, two drives, double sided,
// normal unit mapping (switch 5 closed)
`define DMC_SW_DEFAULT 8'ha0

// reset value of the decoded configuration word
`define DMC_CONFIG_RST 16'h0000

`endif

// ---- core/dmc_pkg.sv ----
`default_nettype none
package dmc_pkg;
    typedef enum logic [1:0] {
        DMC_MODE_NONE = 2'b00,
        DMC_MODE_1 = 2'b01,
        DMC_MODE_2 = 2'b10,
        DMC_MODE_3 = 2'b11
    } dmc_mode_t;

    typedef struct packed {
        logic self_test;
        logic [2:0] test_sel;
        dmc_mode_t mode;
        logic swap_units;
        logic double_sided;
        logic two_drives;
        logic use_dma;
        logic dd_allowed;
        logic ds_media_ok;
        logic ext_formats;
        logic jumper_ok;
        logic valid;
        logic spare;
    } dmc_config_t;

    typedef struct packed {
        logic [7:0] switches;
        logic jumper;
    } dmc_straps_t;
endpackage : dmc_pkg
`default_nettype wire

// ---- core/dmc_decode.sv ----
`include "dmc_defines.svh"
`default_nettype none
module dmc_decode
    import dmc_pkg::*;
(
    input wire dmc_straps_t straps_i,
    output var dmc_config_t cfg_o
);
    wire logic [7:0] sw;
    wire logic test_open;
    wire logic mode1;
    wire logic mode3;
    wire dmc_mode_t mode;

    // true when a switch level reads open
    function automatic logic sw_open(input logic lvl);
        return lvl == `DMC_SW_OPEN;
    endfunction

    // switches arrive as levels, closed reads 0 and open reads 1
    assign sw = straps_i.switches;
    // any open test switch selects a diagnostic routine
    assign test_open = |sw[`DMC_SW_TEST_HI:`DMC_SW_TEST_LO];
    // switch 4 open selects mode 1
    assign mode1 = sw_open(sw[`DMC_SW_MODE]);
    // switch 7 open picks mode 3, closed mode 2
    assign mode3 = ~mode1 & sw_open(sw[`DMC_SW_EXT]);
    assign mode = mode1 ? DMC_MODE_1 : (mode3 ? DMC_MODE_3 : DMC_MODE_2);

    always_comb begin
        cfg_o = '0;
        cfg_o.self_test = test_open;
        cfg_o.test_sel = sw[`DMC_SW_TEST_HI:`DMC_SW_TEST_LO];
        cfg_o.mode = mode;
        cfg_o.swap_units = sw_open(sw[`DMC_SW_MAP]);
        cfg_o.double_sided = sw_open(sw[`DMC_SW_SIDES]);
        cfg_o.two_drives = sw_open(sw[`DMC_SW_COUNT]);
        // mode 1 is programmed i/o, single density, single sided
        // mode 2 and 3 use dma, both densities, either side count
        cfg_o.use_dma = ~mode1;
        cfg_o.dd_allowed = ~mode1;
        cfg_o.ds_media_ok = ~mode1 & cfg_o.double_sided;
        // mode 3 adds the rest of the extended formats
        cfg_o.ext_formats = mode3;
        // host card jumper must be in for mode 1 only
        cfg_o.jumper_ok = (straps_i.jumper == mode1);
        cfg_o.valid = 1'b1;
    end
endmodule // dmc_decode
`default_nettype wire

// ---- core/dmc_top.sv ----
// Summary of operation
// - switch closed reads 0, open reads 1
// - all test switches closed gives normal run
// - switch 4 closed mode 2/3, open mode 1
// - switch 5 open swaps drive unit mapping
// - switch 6 sets sides, switch 8 drives
// - switch 7 closed mode 2, open mode 3
// - mode 1 programmed I/O, single density only
// - mode 2 DMA, both densities, sides set by switch 6
// - mode 3 adds remaining extended formats
// - factory default pattern gives mode 2
`include "dmc_defines.svh"
`default_nettype none
module dmc_top
    import dmc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [7:0] switch_bank_i,
    input wire logic single_density_mode_jumper_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output var dmc_config_t cfg_o,
    output logic run_normal_o,
    output logic diag_run_o,
    output logic [2:0] diag_sel_o,
    output logic unit0_is_right_o,
    output logic cfg_mismatch_o
);
    // ********************************************************
    // pin synchronisers
    // ********************************************************
    logic [7:0] sw_meta_ff;
    logic [7:0] sw_sync_ff;
    logic jmp_meta_ff;
    logic jmp_sync_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sw_meta_ff <= `DMC_SW_DEFAULT;
            sw_sync_ff <= `DMC_SW_DEFAULT;
            jmp_meta_ff <= 1'b0;
            jmp_sync_ff <= 1'b0;
        end else begin
            sw_meta_ff <= switch_bank_i;
            sw_sync_ff <= sw_meta_ff;
            jmp_meta_ff <= single_density_mode_jumper_i;
            jmp_sync_ff <= jmp_meta_ff;
        end
    end

    // ********************************************************
    // initialisation sampling
    // ********************************************************
    logic [1:0] settle_ff;
    logic sample_pend_ff;
    logic reinit_req;
    wire logic sample_now;
    dmc_straps_t straps_ff;
    dmc_straps_t nxt_straps;

    assign reinit_req = wr_i && (addr_i == `DMC_REG_CTRL)
                        && wdata_i[`DMC_CTRL_REINIT];
    // sample once the synchronisers hold the pins after release
    assign sample_now = sample_pend_ff && (settle_ff == 2'h3);
    assign nxt_straps = '{switches: sw_sync_ff, jumper: jmp_sync_ff};

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            settle_ff <= 2'h0;
            sample_pend_ff <= 1'b1;
        end else if (reinit_req) begin
            settle_ff <= 2'h0;
            sample_pend_ff <= 1'b1;
        end else begin
            if (settle_ff != 2'h3) begin
                settle_ff <= settle_ff + 2'h1;
            end
            if (sample_now) begin
                sample_pend_ff <= 1'b0;
            end
        end
    end

    // straps take the factory pattern until first sample
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            straps_ff <= '{switches: `DMC_SW_DEFAULT, jumper: 1'b0};
        end else if (sample_now) begin
            straps_ff <= nxt_straps;
        end
    end

    // ********************************************************
    // decode
    // ********************************************************
    dmc_config_t dec_cfg;

    dmc_decode u_decode (
        .straps_i(straps_ff),
        .cfg_o(dec_cfg)
    );

    // ********************************************************
    // registered outputs
    // ********************************************************
    wire logic [15:0] cfg_word;
    wire logic [15:0] sw_word;
    wire logic [15:0] ctrl_word;
    logic [15:0] nxt_rdata;

    assign cfg_word = dec_cfg;
    assign sw_word = {7'h00, straps_ff.jumper, straps_ff.switches};
    assign ctrl_word = {15'h0000, sample_pend_ff};

    always_comb begin
        nxt_rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                `DMC_REG_SWITCH: nxt_rdata = sw_word;
                `DMC_REG_CONFIG: nxt_rdata = cfg_word;
                `DMC_REG_CTRL: nxt_rdata = ctrl_word;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
            cfg_o <= `DMC_CONFIG_RST;
            run_normal_o <= 1'b0;
            diag_run_o <= 1'b0;
            diag_sel_o <= 3'h0;
            unit0_is_right_o <= 1'b0;
            cfg_mismatch_o <= 1'b0;
        end else begin
            rdata_o <= nxt_rdata;
            // config outputs hold stable between samples, run, diag and mismatch flags stay low while a sample is pending
            cfg_o <= dec_cfg;
            run_normal_o <= ~dec_cfg.self_test & ~sample_pend_ff;
            diag_run_o <= dec_cfg.self_test & ~sample_pend_ff;
            diag_sel_o <= dec_cfg.test_sel;
            unit0_is_right_o <= dec_cfg.swap_units;
            // host jumper must agree with mode select
            cfg_mismatch_o <= ~dec_cfg.jumper_ok & ~sample_pend_ff;
        end
    end
endmodule // dmc_top
`default_nettype wire

// ---- verification/dmc_host_card.sv ----
`default_nettype none
module dmc_host_card (
    input wire logic mode1_i,
    output logic jumper_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // lowest selectable interrupt level, 4 up to 7
    localparam int IRQ_LEVEL = 4;
    assign jumper_o = mode1_i;
endmodule // dmc_host_card
`default_nettype wire

// ---- verification/dmc_monitor.sv ----
`default_nettype none
module dmc_monitor
    import dmc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire dmc_config_t cfg_o,
    input wire logic run_normal_o,
    input wire logic diag_run_o,
    input wire logic [2:0] diag_sel_o,
    input wire logic unit0_is_right_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    // ****
    // checks
    // ****
    a_diag_excl: assert property (run_normal_o |-> !diag_run_o)
        else $error("normal and diagnostic run together");
    a_diag_sel: assert property (diag_run_o |-> diag_sel_o != 3'h0)
        else $error("diagnostic run with no test switch open");
    a_mode_set: assert property (
        cfg_o.valid |-> cfg_o.mode != DMC_MODE_NONE)
        else $error("valid config without a mode");
    a_swap_map: assert property (
        cfg_o.valid |-> unit0_is_right_o == cfg_o.swap_units)
        else $error("unit mapping output disagrees with config");
    a_mode1_pio: assert property (
        cfg_o.valid && cfg_o.mode == DMC_MODE_1
        |-> !cfg_o.use_dma && !cfg_o.ds_media_ok && !cfg_o.dd_allowed)
        else $error("mode 1 allows dma or double sided media");
    a_mode2_dma: assert property (
        cfg_o.valid && cfg_o.mode == DMC_MODE_2
        |-> cfg_o.use_dma && cfg_o.dd_allowed && !cfg_o.ext_formats)
        else $error("mode 2 transfer or format set wrong");
    a_mode3_ext: assert property (
        cfg_o.valid && cfg_o.mode == DMC_MODE_3
        |-> cfg_o.use_dma && cfg_o.ext_formats)
        else $error("mode 3 lacks extended formats");
    a_cfg_hold: assert property (
        (!wr_i && cfg_o.valid)[*8] |=> $stable(cfg_o))
        else $error("config changed without initialization");
    cover property (run_normal_o);
    cover property (diag_run_o);
    cover property (cfg_o.mode == DMC_MODE_3);
endmodule // dmc_monitor
bind dmc_top dmc_monitor dmc_monitor_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .wr_i(wr_i), .cfg_o(cfg_o), .run_normal_o(run_normal_o),
    .diag_run_o(diag_run_o), .diag_sel_o(diag_sel_o),
    .unit0_is_right_o(unit0_is_right_o));
`default_nettype wire

// ---- verification/dmc_top_tb.sv ----
`default_nettype none
module dmc_top_tb
    import dmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, reset_i, wr, rd, inst, jumper, run_n, diag, u0r, mism;
    logic [7:0] sw;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [2:0] dsel;
    dmc_config_t cfg;
    int err_total = 0;
    int check_count = 0;
    dmc_host_card dmc_host_card_i (.mode1_i(inst), .jumper_o(jumper));
    dmc_top dmc_top_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .switch_bank_i(sw), .single_density_mode_jumper_i(jumper),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .cfg_o(cfg), .run_normal_o(run_n),
        .diag_run_o(diag), .diag_sel_o(dsel), .unit0_is_right_o(u0r),
        .cfg_mismatch_o(mism));
    initial mclk_i = 1'b0;
    always #2.5 mclk_i = ~mclk_i;
    // ****
    // tasks
    // ****
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus_wr(logic [3:0] a, logic [15:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(logic [3:0] a, logic [15:0] e, string nm);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    function automatic logic [15:0] exp_cfg(logic [7:0] s, logic j);
        dmc_config_t c;
        c = '0;
        c.self_test = |s[2:0];
        c.test_sel = s[2:0];
        c.mode = s[3] ? DMC_MODE_1 : (s[6] ? DMC_MODE_3 : DMC_MODE_2);
        c.swap_units = s[4];
        c.double_sided = s[5];
        c.two_drives = s[7];
        c.use_dma = !s[3];
        c.dd_allowed = !s[3];
        c.ds_media_ok = !s[3] && s[5];
        c.ext_formats = !s[3] && s[6];
        c.jumper_ok = j == s[3];
        c.valid = 1'b1;
        return c;
    endfunction
    task automatic run_cfg(logic [7:0] s, logic j);
        logic [15:0] e;
        e = exp_cfg(s, j);
        @(posedge mclk_i);
        sw <= s;
        inst <= j;
        bus_wr(4'h2, 16'h0001);
        bus_rd(4'h2, 16'h0001, "pending");
        repeat (10) @(posedge mclk_i);
        #1;
        chk("cfg", e, cfg);
        chk("outs", {9'h0, ~e[15], e[15:12], e[9], ~e[2]},
            {9'h0, run_n, diag, dsel, u0r, mism});
        bus_rd(4'h1, e, "cfg_reg");
        bus_rd(4'h0, {7'h0, j, s}, "sw_reg");
        @(posedge mclk_i);
        sw <= ~s;
        bus_wr(4'h2, 16'hfffe);
        repeat (12) @(posedge mclk_i);
        #1;
        chk("hold", e, cfg);
        bus_rd(4'h2, 16'h0000, "idle");
    endtask
    task automatic print_verdict;
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        sw = 8'ha0;
        inst = 1'b0;
        addr = 4'h0;
        wdata = 16'h0;
        wr = 1'b0;
        rd = 1'b0;
        reset_i = 1'b1;
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        chk("rst", 16'h0, cfg);
        @(posedge mclk_i);
        #1;
        chk("rst_dflt", exp_cfg(8'ha0, 1'b0), cfg);
        repeat (9) @(posedge mclk_i);
        #1;
        chk("default", exp_cfg(8'ha0, 1'b0), cfg);
        run_cfg(8'h08, 1'b1);
        run_cfg(8'h40, 1'b0);
        run_cfg(8'h30, 1'b0);
        run_cfg(8'h85, 1'b0);
        run_cfg(8'h02, 1'b1);
        bus_rd(4'hf, 16'h0, "unmapped");
        print_verdict;
    end
    initial begin
        #20000;
        err_total++;
        print_verdict;
    end
endmodule // dmc_top_tb
`default_nettype wire
